// File: design/crf_core_regs.v
// Architectural register set of the core: general registers, program
// counter, multiply/divide results, format decode and address forming.
// Assumes decoder and pipeline run on clk and drive inputs synchronously.
//
// Function
// - Thirty-two 64-bit registers, 5-bit instruction index
// - Index zero reads zero, writes discarded
// - Link jumps write return address to 31
// - High and low multiply/divide result registers
// - Separate 64-bit program counter register
// - Width 32 or 64 chosen by mode
// - 32-bit words in immediate, jump, register formats
// - Load/store address is base plus sign-extended offset
// - Immediate operand is signed 16-bit field
// - Jump target from 26-bit field, upper PC
// - Branch target from PC-relative 16-bit offset
// - Byte, halfword, word, doubleword data sizes
// - Little-endian byte order only
// - Byte zero occupies least significant bits
// - Natural alignment for halfword, word, doubleword
`timescale 1ns/1ps
`include "crf_consts.vh"

module crf_core_regs (
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // Operating mode
  input  wire        mode64,
  // Instruction from decoder
  input  wire        insn_valid,
  input  wire [31:0] insn_word,
  // Result write port
  input  wire        result_wr_en,
  input  wire [4:0]  result_wr_index,
  input  wire [63:0] result_wr_data,
  // Control flow strobes
  input  wire        jump_and_link_immediate,
  input  wire        jump_and_link_via_register,
  input  wire        pc_advance,
  input  wire        branch_taken,
  input  wire        jump_taken,
  input  wire        jump_reg_taken,
  // Multiply/divide results
  input  wire        muldiv_wr_en,
  input  wire [63:0] muldiv_high_in,
  input  wire [63:0] muldiv_low_in,
  // Memory access
  input  wire [1:0]  access_size,
  input  wire        load_unsigned,
  input  wire [2:0]  load_addr_low,
  input  wire [63:0] mem_rdata,
  // Operands and decode
  output reg  [63:0] src_a_data,
  output reg  [63:0] src_b_data,
  output reg  [63:0] imm_operand,
  output reg  [1:0]  insn_format,
  output reg         operands_valid,
  // Addresses and lanes
  output reg  [63:0] eff_addr,
  output reg  [7:0]  byte_enable,
  output reg  [63:0] store_lanes,
  output reg         misaligned,
  output reg  [63:0] load_value,
  // Architectural state
  output reg  [63:0] instruction_pointer,
  output reg  [63:0] muldiv_high_result,
  output reg  [63:0] muldiv_low_result,
  output reg         write_refused
);

  // ============================================================
  // Width fitting for the current mode
  // In 32-bit mode values keep the 64-bit form, sign-extended from bit 31
  function [63:0] crf_fit;
    input [63:0] v;
    input        m64;
    begin
      crf_fit = m64 ? v : {{`CRF_WLEN{v[`CRF_WORD_MSB]}}, v[`CRF_WORD_MSB:0]};
    end
  endfunction

  // ============================================================
  // Instruction field extraction
  wire [5:0]  opcode;                // Major opcode
  wire [4:0]  rs_index;              // First source index
  wire [4:0]  rt_index;              // Second source index
  wire [15:0] imm16;                 // Immediate or offset field
  wire [25:0] target26;              // Jump target field
  wire [63:0] imm_sext;              // Signed immediate, full width
  wire [63:0] pc_reg;                // Current program counter

  assign opcode   = insn_word[`CRF_OP_HI:`CRF_OP_LO];
  assign rs_index = insn_word[`CRF_RS_HI:`CRF_RS_LO];
  assign rt_index = insn_word[`CRF_RT_HI:`CRF_RT_LO];
  assign imm16    = insn_word[`CRF_IMM_HI:`CRF_IMM_LO];
  assign target26 = insn_word[`CRF_TGT_HI:`CRF_TGT_LO];
  assign imm_sext = {{48{imm16[15]}}, imm16};

  // ============================================================
  // Write port arbitration
  // A link write takes the single write port; a result write in the
  // same cycle is refused rather than silently merged
  wire        link_req;              // Either link jump this cycle
  wire        wr_en;                 // Port write enable
  wire [4:0]  wr_index;              // Port write index
  wire [63:0] wr_data;               // Port write data, mode fitted
  wire [63:0] link_addr;             // Return address

  assign link_req  = jump_and_link_immediate | jump_and_link_via_register;
  assign link_addr = crf_fit(pc_reg + `CRF_LINK_OFFSET, mode64);
  assign wr_en     = link_req | result_wr_en;
  assign wr_index  = link_req ? `CRF_LINK_IDX : result_wr_index;
  assign wr_data   = link_req ? link_addr : crf_fit(result_wr_data, mode64);

  // ============================================================
  // General register entries
  wire [63:0] entry_q [0:`CRF_NREG-1];   // Entry read values

  // Entry zero has no storage and reads zero
  assign entry_q[0] = `CRF_DATA_RESET;

  genvar g;
  generate
    for (g = 1; g < `CRF_NREG; g = g + 1)
    begin : g_entry
      localparam [4:0] ENTRY_IDX = g;
      reg [63:0] entry_reg;              // One general register
      // Entry loads when the port targets it
      always @(posedge clk)
      begin
        if (rst)
        begin
          entry_reg <= `CRF_DATA_RESET;
        end
        else if (wr_en && (wr_index == ENTRY_IDX))
        begin
          entry_reg <= wr_data;
        end
      end
      assign entry_q[g] = entry_reg;
    end
  endgenerate

  // ============================================================
  // Two read ports with write-through forwarding
  // Forwarding lets a same-cycle write be seen without a stall; index
  // zero never forwards so it stays zero even when written
  wire        fwd_a;                 // Port A hits the write
  wire        fwd_b;                 // Port B hits the write
  wire [63:0] read_a;                // Port A value
  wire [63:0] read_b;                // Port B value

  assign fwd_a  = wr_en && (wr_index == rs_index) && (rs_index != `CRF_ZERO_IDX);
  assign fwd_b  = wr_en && (wr_index == rt_index) && (rt_index != `CRF_ZERO_IDX);
  assign read_a = fwd_a ? wr_data : crf_fit(entry_q[rs_index], mode64);
  assign read_b = fwd_b ? wr_data : crf_fit(entry_q[rt_index], mode64);

  // ============================================================
  // Format decode
  reg [1:0] fmt_next;                // Decoded format

  // Every word falls in one of three formats
  always @*
  begin
    if (opcode == `CRF_OPC_REG)
    begin
      fmt_next = `CRF_FMT_REG;
    end
    else if (opcode[`CRF_OP_HI-`CRF_OP_LO:`CRF_OPCLS_LO-`CRF_OP_LO] == `CRF_OPC_JUMP_CLS)
    begin
      fmt_next = `CRF_FMT_JUMP;
    end
    else
    begin
      fmt_next = `CRF_FMT_IMM;
    end
  end

  // ============================================================
  // Address forming
  wire [63:0] pc_plus4;              // Sequential address
  wire [63:0] jump_target;           // Absolute jump target
  wire [63:0] branch_target;         // PC-relative target
  wire [63:0] addr_next;             // Load/store address
  reg  [63:0] pc_next;               // Next program counter

  assign pc_plus4      = pc_reg + `CRF_INSN_STEP;
  assign jump_target   = {pc_plus4[63:`CRF_PC_KEEP_LO], target26, 2'b00};
  assign branch_target = pc_plus4 + {imm_sext[61:0], 2'b00};
  assign addr_next     = crf_fit(read_a + imm_sext, mode64);

  // Register jump outranks jump, then branch, then advance
  always @*
  begin
    if (jump_reg_taken)
    begin
      pc_next = read_a;
    end
    else if (jump_taken)
    begin
      pc_next = jump_target;
    end
    else if (branch_taken)
    begin
      pc_next = branch_target;
    end
    else if (pc_advance)
    begin
      pc_next = pc_plus4;
    end
    else
    begin
      pc_next = pc_reg;
    end
  end

  // ============================================================
  // Byte lane alignment
  wire [7:0]  lane_en;               // Store byte enables
  wire [63:0] lane_data;             // Store data in lanes
  wire        lane_misaligned;       // Alignment fault
  wire [63:0] lane_load;             // Extracted load value

  crf_lane_align u_lane (
    .st_addr_low   (addr_next[2:0]),
    .st_size       (access_size),
    .st_data       (read_b),
    .st_byte_en    (lane_en),
    .st_lanes      (lane_data),
    .st_misaligned (lane_misaligned),
    .ld_addr_low   (load_addr_low),
    .ld_size       (access_size),
    .ld_unsigned   (load_unsigned),
    .ld_lanes      (mem_rdata),
    .ld_value      (lane_load)
  );

  // ============================================================
  // Program counter and multiply/divide registers
  assign pc_reg = instruction_pointer;

  // Dedicated counter apart from the general entries
  always @(posedge clk)
  begin
    if (rst)
    begin
      instruction_pointer <= `CRF_PC_RESET;
    end
    else
    begin
      instruction_pointer <= crf_fit(pc_next, mode64);
    end
  end

  // Upper doubleword to high, lower to low
  always @(posedge clk)
  begin
    if (rst)
    begin
      muldiv_high_result <= `CRF_DATA_RESET;
      muldiv_low_result  <= `CRF_DATA_RESET;
    end
    else if (muldiv_wr_en)
    begin
      muldiv_high_result <= crf_fit(muldiv_high_in, mode64);
      muldiv_low_result  <= crf_fit(muldiv_low_in, mode64);
    end
  end

  // ============================================================
  // Registered operand and address outputs
  // Operands hold their last value when no instruction is presented
  always @(posedge clk)
  begin
    if (rst)
    begin
      src_a_data     <= `CRF_DATA_RESET;
      src_b_data     <= `CRF_DATA_RESET;
      imm_operand    <= `CRF_DATA_RESET;
      insn_format    <= `CRF_FMT_IMM;
      operands_valid <= 1'b0;
      eff_addr       <= `CRF_DATA_RESET;
      byte_enable    <= 8'h00;
      store_lanes    <= `CRF_DATA_RESET;
      misaligned     <= 1'b0;
    end
    else
    begin
      operands_valid <= insn_valid;
      if (insn_valid)
      begin
        src_a_data  <= read_a;
        src_b_data  <= read_b;
        imm_operand <= crf_fit(imm_sext, mode64);
        insn_format <= fmt_next;
        eff_addr    <= addr_next;
        byte_enable <= lane_en;
        store_lanes <= lane_data;
        misaligned  <= lane_misaligned;
      end
    end
  end

  // ============================================================
  // Load result and refusal flag
  always @(posedge clk)
  begin
    if (rst)
    begin
      load_value    <= `CRF_DATA_RESET;
      write_refused <= 1'b0;
    end
    else
    begin
      load_value    <= crf_fit(lane_load, mode64);
      write_refused <= link_req & result_wr_en;
    end
  end

endmodule // crf_core_regs

// File: design/crf_consts.vh
// Constants shared by the core register file and its lane aligner.
// Assumes inclusion by bare name from every design file of the block.
`ifndef CRF_CONSTS_VH
`define CRF_CONSTS_VH

// ============================================================
// Widths and register indices
`define CRF_XLEN          64
`define CRF_WLEN          32
`define CRF_WORD_MSB      31
`define CRF_NREG          32
`define CRF_IDX_W         5
`define CRF_ZERO_IDX      5'h00
`define CRF_LINK_IDX      5'h1F

// ============================================================
// Instruction word field positions
`define CRF_OP_HI         31
`define CRF_OP_LO         26
`define CRF_OPCLS_LO      27
`define CRF_RS_HI         25
`define CRF_RS_LO         21
`define CRF_RT_HI         20
`define CRF_RT_LO         16
`define CRF_IMM_HI        15
`define CRF_IMM_LO        0
`define CRF_TGT_HI        25
`define CRF_TGT_LO        0
`define CRF_PC_KEEP_LO    28

// ============================================================
// Format decode values and format codes
`define CRF_OPC_REG       6'h00
`define CRF_OPC_JUMP_CLS  5'h01
`define CRF_FMT_IMM       2'h0
`define CRF_FMT_JUMP      2'h1
`define CRF_FMT_REG       2'h2

// ============================================================
// Access sizes
`define CRF_SZ_BYTE       2'h0
`define CRF_SZ_HALF       2'h1
`define CRF_SZ_WORD       2'h2
`define CRF_SZ_DWORD      2'h3

// ============================================================
// Reset values and address steps
`define CRF_PC_RESET      64'h0000_0000_0000_0000
`define CRF_DATA_RESET    64'h0000_0000_0000_0000
`define CRF_INSN_STEP     64'h0000_0000_0000_0004
`define CRF_LINK_OFFSET   64'h0000_0000_0000_0008

`endif

// File: design/crf_lane_align.v
// Little-endian byte lane placement for stores and extraction for loads.
// Assumes purely combinational use; the caller registers every result.
`timescale 1ns/1ps
`include "crf_consts.vh"

module crf_lane_align (
  // Store side
  input  wire [2:0]  st_addr_low,
  input  wire [1:0]  st_size,
  input  wire [63:0] st_data,
  output wire [7:0]  st_byte_en,
  output wire [63:0] st_lanes,
  output reg         st_misaligned,
  // Load side
  input  wire [2:0]  ld_addr_low,
  input  wire [1:0]  ld_size,
  input  wire        ld_unsigned,
  input  wire [63:0] ld_lanes,
  output reg  [63:0] ld_value
);

  // ============================================================
  // Store byte enables
  wire [3:0]  st_nbytes;             // Bytes in the access
  wire [3:0]  st_end;                // One past the last byte
  wire [63:0] ld_shift;              // Load bytes moved to bit 0
  wire        sx;                    // Sign bit chosen by size

  assign st_nbytes = 4'h1 << st_size;
  assign st_end    = {1'b0, st_addr_low} + st_nbytes;

  // One enable per byte lane; byte 0 at lowest address is bits 7:0
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1)
    begin : g_lane
      localparam [3:0] BYTE_IDX = i;
      assign st_byte_en[i] = (BYTE_IDX >= {1'b0, st_addr_low}) && (BYTE_IDX < st_end);
    end
  endgenerate

  // Data shifted up to its lane position
  assign st_lanes = st_data << {st_addr_low, 3'b000};

  // ============================================================
  // Alignment check per size
  always @*
  begin
    case (st_size)
      `CRF_SZ_HALF:  st_misaligned = st_addr_low[0];
      `CRF_SZ_WORD:  st_misaligned = |st_addr_low[1:0];
      `CRF_SZ_DWORD: st_misaligned = |st_addr_low;
      default:       st_misaligned = 1'b0;
    endcase
  end

  // ============================================================
  // Load extraction, sign or zero extended
  assign ld_shift = ld_lanes >> {ld_addr_low, 3'b000};
  assign sx = ~ld_unsigned & ((ld_size == `CRF_SZ_BYTE) ? ld_shift[7] :
                              (ld_size == `CRF_SZ_HALF) ? ld_shift[15] : ld_shift[31]);

  // Four data sizes
  always @*
  begin
    case (ld_size)
      `CRF_SZ_BYTE: ld_value = {{56{sx}}, ld_shift[7:0]};
      `CRF_SZ_HALF: ld_value = {{48{sx}}, ld_shift[15:0]};
      `CRF_SZ_WORD: ld_value = {{32{sx}}, ld_shift[31:0]};
      default:      ld_value = ld_shift;
    endcase
  end

endmodule // crf_lane_align

// File: verif/crf_core_regs_checker.sv
// Checker for the core register set, watching top-level ports only.
// Assumes one clk domain and synchronous active-high rst.
`timescale 1ns/1ps
module crf_core_regs_checker (
  // Clock, reset, mode
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        mode64,
  // Requests
  input wire logic        insn_valid,
  input wire logic [31:0] insn_word,
  input wire logic        result_wr_en,
  input wire logic        jump_and_link_immediate,
  input wire logic        jump_and_link_via_register,
  input wire logic        pc_advance,
  input wire logic        branch_taken,
  input wire logic        jump_taken,
  input wire logic        jump_reg_taken,
  input wire logic        muldiv_wr_en,
  input wire logic [63:0] muldiv_high_in,
  input wire logic [1:0]  access_size,
  // Results
  input wire logic [63:0] src_a_data,
  input wire logic [63:0] imm_operand,
  input wire logic [1:0]  insn_format,
  input wire logic [63:0] eff_addr,
  input wire logic        misaligned,
  input wire logic [63:0] instruction_pointer,
  input wire logic [63:0] muldiv_high_result,
  input wire logic        write_refused
);
  // ============================================================
  // Helpers
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire [63:0] pc4    = instruction_pointer + 64'h0000_0000_0000_0004;  // Next sequential PC
  wire [63:0] jtgt   = {pc4[63:28], insn_word[25:0], 2'h0};            // Jump target
  wire [63:0] imm_sx = {{48{insn_word[15]}}, insn_word[15:0]};         // Signed immediate
  wire        no_jmp = !jump_reg_taken && !jump_taken;                 // No jump strobe
  // Link write colliding with a result write
  sequence link_clash;
    (jump_and_link_immediate || jump_and_link_via_register) && result_wr_en;
  endsequence
  // Word access being issued
  sequence word_insn;
    insn_valid && access_size == 2'h2;
  endsequence
  // ============================================================
  // Assertions
  pc_step_a:
    assert property (pc_advance && no_jmp && !branch_taken && mode64 |=> instruction_pointer == $past(pc4))
      else $error("pc step wrong");
  pc_hold_a:
    assert property (!pc_advance && !branch_taken && no_jmp && mode64 |=> $stable(instruction_pointer))
      else $error("pc moved without strobe");
  jump_tgt_a:
    assert property (jump_taken && !jump_reg_taken && mode64 |=> instruction_pointer == $past(jtgt))
      else $error("jump target wrong");
  zero_src_a:
    assert property (insn_valid && insn_word[25:21] == 5'h00 |=> src_a_data == 64'h0000_0000_0000_0000)
      else $error("index zero not zero");
  fmt_reg_a:
    assert property (insn_valid && insn_word[31:26] == 6'h00 |=> insn_format == 2'h2)
      else $error("register format wrong");
  link_refuse_a:
    assert property (link_clash |=> write_refused)
      else $error("clash not flagged");
  no_refuse_a:
    assert property (!result_wr_en |=> !write_refused)
      else $error("refusal without write");
  muldiv_hi_a:
    assert property (muldiv_wr_en && mode64 |=> muldiv_high_result == $past(muldiv_high_in))
      else $error("high result wrong");
  imm_sext_a:
    assert property (insn_valid |=> imm_operand == $past(imm_sx))
      else $error("immediate wrong");
  word_align_a:
    assert property (word_insn |=> misaligned == (eff_addr[1:0] != 2'h0))
      else $error("word alignment flag wrong");
endmodule // crf_core_regs_checker

bind crf_core_regs crf_core_regs_checker chk_u (.clk, .rst, .mode64, .insn_valid, .insn_word, .result_wr_en,
  .jump_and_link_immediate, .jump_and_link_via_register, .pc_advance, .branch_taken, .jump_taken,
  .jump_reg_taken, .muldiv_wr_en, .muldiv_high_in, .access_size, .src_a_data, .imm_operand, .insn_format,
  .eff_addr, .misaligned, .instruction_pointer, .muldiv_high_result, .write_refused);

// File: verif/crf_mem_model.sv
// Memory-side model: one doubleword built from eight byte lanes.
// Assumes the bench loads bytes between loads through put_byte.
`timescale 1ns/1ps
module crf_mem_model (
  // Read enable
  input  wire logic        rd_en,
  // Doubleword to the core
  output logic      [63:0] rdata
);
  logic [63:0] packed_dw;      // Lane image, byte k at bits 8k+7:8k
  // Bench access to contents; lowest address lands in the lowest bits
  task automatic put_byte(input int k, input logic [7:0] b);
    packed_dw[8*k +: 8] = b;
  endtask
  // Released bus shows inverse, not a stale copy
  assign rdata = rd_en ? packed_dw : ~packed_dw;
endmodule // crf_mem_model

// File: verif/tb_cpu_core_register_file.sv
// Self-checking bench for the core register set.
// Assumes the checker is bound separately and a 25 MHz clk.
`timescale 1ns/1ps
module tb_cpu_core_register_file;
  // ============================================================
  // Signals
  logic        clk = 0, rst = 1, mode64 = 1, insn_valid = 0, load_unsigned = 0, rd_en = 1;
  logic        result_wr_en = 0, jump_and_link_immediate = 0, jump_and_link_via_register = 0;
  logic        pc_advance = 0, branch_taken = 0, jump_taken = 0, jump_reg_taken = 0, muldiv_wr_en = 0;
  logic [31:0] insn_word = 0;
  logic [4:0]  result_wr_index = 0;
  logic [63:0] result_wr_data = 0, muldiv_high_in = 0, muldiv_low_in = 0;
  logic [1:0]  access_size = 0;
  logic [2:0]  load_addr_low = 0;
  wire  [63:0] mem_rdata, src_a_data, src_b_data, imm_operand, eff_addr, store_lanes, load_value;
  wire  [63:0] instruction_pointer, muldiv_high_result, muldiv_low_result;
  wire  [1:0]  insn_format;
  wire  [7:0]  byte_enable;
  wire         operands_valid, misaligned, write_refused;
  logic [63:0] regs [32];  // Expected registers
  logic [63:0] pc_e, v, w;
  logic [15:0] imm;
  logic [7:0]  bt [8];     // Expected memory bytes
  int          errors = 0, checks = 0, k;

  crf_core_regs dut_u (.*);
  crf_mem_model mem_u (.rd_en, .rdata(mem_rdata));

  always #20 clk = ~clk;
  // ============================================================
  // Helpers
  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tick;
    @(posedge clk);
    @(negedge clk);
  endtask
  function automatic logic [63:0] fit(input logic [63:0] x);
    return mode64 ? x : {{32{x[31]}}, x[31:0]};
  endfunction
  function automatic logic [63:0] ext(input logic [63:0] x, input logic [1:0] sz, input logic u);
    case (sz)
      2'h0: return {{56{x[7] & !u}}, x[7:0]};
      2'h1: return {{48{x[15] & !u}}, x[15:0]};
      2'h2: return {{32{x[31] & !u}}, x[31:0]};
      default: return x;
    endcase
  endfunction
  function automatic logic [1:0] fmt(input logic [31:0] x);
    if (x[31:26] == 6'h00)
      return 2'h2;
    if (x[31:27] == 5'h01)
      return 2'h1;
    return 2'h0;
  endfunction
  task automatic wr(input logic [4:0] i, input logic [63:0] d);
    result_wr_en = 1;
    result_wr_index = i;
    result_wr_data = d;
    tick;
    if (i != 0)
      regs[i] = fit(d);
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Hang guard, far beyond the hundred or so cycles needed
  initial
  begin
    #(40 * 20000);
    errors++;
    summarize;
  end
  // ============================================================
  // Main sequence
  initial
  begin
    void'($urandom(9));
    foreach (regs[i]) regs[i] = 0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst = 0;
    pc_e = 0;
    chk("pc reset", instruction_pointer, pc_e);
    // Write each index while reading it: forwarding and both read ports
    for (int i = 0; i < 32; i++)
    begin
      insn_valid = 1;
      insn_word = {6'h00, 5'(i), 5'(31 - i), 16'h0000};
      wr(5'(i), {$urandom, $urandom});
      chk("valid", operands_valid, 1'b1);
      chk("src a", src_a_data, regs[i]);
      chk("src b", src_b_data, regs[31 - i]);
      chk("format", insn_format, 2'h2);
    end
    result_wr_en = 0;
    // Addresses, lanes and alignment over every size
    for (int i = 0; i < 16; i++)
    begin
      imm = (i == 0) ? 16'h8000 : 16'($urandom);
      access_size = 2'(i);
      insn_valid = 1;
      insn_word = {6'h23, 5'($urandom), 5'($urandom), imm};
      tick;
      v = regs[insn_word[25:21]] + {{48{imm[15]}}, imm};
      w = ((64'h1 << (1 << i % 4)) - 1) << v[2:0];
      chk("eff addr", eff_addr, v);
      chk("imm", imm_operand, {{48{imm[15]}}, imm});
      chk("format", insn_format, 2'h0);
      chk("misaligned", misaligned, (v[2:0] & 3'((1 << i % 4) - 1)) != 0);
      chk("byte enable", byte_enable, w[7:0]);
      chk("store lanes", store_lanes, regs[insn_word[20:16]] << 8 * v[2:0]);
    end
    insn_valid = 0;
    // Loads of every size and extension from little-endian memory
    for (int i = 0; i < 16; i++)
    begin
      access_size = 2'(i);
      load_unsigned = i[2];
      load_addr_low = 3'($urandom) & ~3'((1 << i % 4) - 1);
      v = 0;
      for (int b = 7; b >= 0; b--)
      begin
        bt[b] = 8'($urandom);
        mem_u.put_byte(b, bt[b]);
        v = {v[55:0], bt[b]};
      end
      tick;
      chk("load", load_value, ext(v >> 8 * load_addr_low, 2'(i), i[2]));
      chk("idle valid", operands_valid, 1'b0);
    end
    // Program counter strobes, higher priority set together with lower ones
    for (int i = 0; i < 12; i++)
    begin
      k = $urandom % 4;
      insn_word = $urandom;
      if (k == 2)
        insn_word[31:27] = 5'h01;
      insn_valid = 1;
      {jump_reg_taken, jump_taken, branch_taken, pc_advance} = 4'hF >> (3 - k);
      tick;
      v = pc_e + 64'h4;
      case (k)
        0: pc_e = v;
        1: pc_e = v + {{46{insn_word[15]}}, insn_word[15:0], 2'h0};
        2: pc_e = {v[63:28], insn_word[25:0], 2'h0};
        default: pc_e = regs[insn_word[25:21]];
      endcase
      chk("pc", instruction_pointer, pc_e);
      chk("format", insn_format, fmt(insn_word));
    end
    {jump_reg_taken, jump_taken, branch_taken, pc_advance, insn_valid} = 5'h00;
    // Both link kinds colliding with a result write
    for (int i = 0; i < 2; i++)
    begin
      {jump_and_link_via_register, jump_and_link_immediate} = 2'(i + 1);
      w = regs[5];
      wr(5'h05, {$urandom, $urandom});
      {jump_and_link_via_register, jump_and_link_immediate} = 2'h0;
      result_wr_en = 0;
      regs[5] = w;
      regs[31] = pc_e + 64'h8;
      chk("refused", write_refused, 1'b1);
      insn_valid = 1;
      insn_word = {6'h00, 5'h1F, 5'h05, 16'h0000};
      tick;
      insn_valid = 0;
      chk("link", src_a_data, pc_e + 64'h8);
      chk("dropped", src_b_data, regs[5]);
    end
    // Multiply and divide results
    muldiv_high_in = {$urandom, $urandom};
    muldiv_low_in = {$urandom, $urandom};
    muldiv_wr_en = 1;
    tick;
    muldiv_wr_en = 0;
    chk("high", muldiv_high_result, muldiv_high_in);
    chk("low", muldiv_low_result, muldiv_low_in);
    // Narrow mode sign-extends from bit 31
    mode64 = 0;
    wr(5'h07, 64'h1234_5678_8000_0001);
    result_wr_en = 0;
    insn_valid = 1;
    insn_word = {6'h00, 5'h07, 5'h07, 16'h0000};
    pc_advance = 1;
    tick;
    {insn_valid, pc_advance} = 2'h0;
    pc_e = fit(pc_e + 64'h4);
    chk("narrow reg", src_a_data, 64'hFFFF_FFFF_8000_0001);
    chk("narrow pc", instruction_pointer, pc_e);
    mode64 = 1;
    summarize;
  end
endmodule // tb_cpu_core_register_file
